/* File: verilog/sdc_pkg.sv */
package sdc_pkg;
	// pin widths
	localparam int ADDR_W = 13;
	localparam int COL_W = 9;
	localparam int BANK_W = 2;
	localparam int NBANK = 4;
	localparam int DQ_W = 16;
	localparam int DQM_W = 2;
	localparam int AP_BIT = 10;

	// register bus
	localparam int AVS_AW = 4;
	localparam logic [AVS_AW-1:0] REG_MODE = 4'h0;
	localparam logic [AVS_AW-1:0] REG_STAT = 4'h4;

	// mode register fields
	localparam int MODE_W = 6;
	localparam int MODE_LEN_LSB = 0;
	localparam int MODE_ILV_BIT = 3;
	localparam int MODE_LAT_LSB = 4;
	localparam logic [MODE_W-1:0] MODE_RST = 6'h23;

	// burst length codes
	localparam logic [2:0] LEN_1 = 3'h0;
	localparam logic [2:0] LEN_2 = 3'h1;
	localparam logic [2:0] LEN_4 = 3'h2;
	localparam logic [2:0] LEN_8 = 3'h3;
	localparam logic [2:0] LEN_FULL = 3'h7;

	// timing in clocks
	localparam logic [1:0] WR_RECOVERY_CYC = 2'h2;
	localparam logic [1:0] DQM_RD_LAT = 2'h2;
	localparam logic [1:0] LAT_MIN = 2'h2;

	typedef enum logic [2:0] {
		CMD_NOP = 3'b000,
		CMD_ACT = 3'b001,
		CMD_RD = 3'b010,
		CMD_WR = 3'b011,
		CMD_PRE = 3'b100,
		CMD_BST = 3'b101,
		CMD_SREF = 3'b110
	} sdc_cmd_e;

	typedef struct packed {
		logic cke;
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic [DQM_W-1:0] dqm;
		logic [BANK_W-1:0] bank;
		logic [ADDR_W-1:0] addr;
	} sdc_pin_s;

	typedef struct packed {
		logic valid;
		logic [DQ_W-1:0] data;
	} sdc_beat_s;
endpackage

/* File: verilog/sdc_col_gen.sv */
`timescale 1ns/1ns
`default_nettype none
module sdc_col_gen import sdc_pkg::*; (
	// burst position
	input wire logic [COL_W-1:0] i_start,
	input wire logic [COL_W-1:0] i_beat,
	// mode
	input wire logic [2:0] i_len,
	input wire logic i_ilv,
	// result
	output logic [COL_W-1:0] o_col,
	output logic [COL_W-1:0] o_mask,
	output logic o_full
);
	logic [COL_W-1:0] step;

	always_comb begin
		o_full = (i_len == LEN_FULL);
		case (i_len)
			LEN_2: o_mask = 9'h001;
			LEN_4: o_mask = 9'h003;
			LEN_8: o_mask = 9'h007;
			LEN_FULL: o_mask = 9'h1ff;
			default: o_mask = 9'h000;
		endcase
		if (i_ilv && !o_full) begin
			step = i_start ^ i_beat;
		end else begin
			step = i_start + i_beat;
		end
		o_col = (i_start & ~o_mask) | (step & o_mask);
	end
endmodule
`default_nettype wire

/* File: verilog/sdc_rd_pipe.sv */
`timescale 1ns/1ns
`default_nettype none
module sdc_rd_pipe import sdc_pkg::*; #(
	parameter int DEPTH = 1
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// beat in
	input wire sdc_beat_s i_beat,
	input wire logic [1:0] i_sel,
	// beat out
	output sdc_beat_s o_beat
);
	sdc_beat_s stage_ff [DEPTH];
	sdc_beat_s nxt_stage [DEPTH];

	always_comb begin
		nxt_stage[0] = i_beat;
		for (int i = 1; i < DEPTH; i++) begin
			nxt_stage[i] = stage_ff[i-1];
		end
		if (i_sel == 2'h0 || int'(i_sel) > DEPTH) begin
			o_beat = i_beat;
		end else begin
			o_beat = stage_ff[int'(i_sel) - 1];
		end
	end

	always_ff @(posedge i_clk) begin
		for (int i = 0; i < DEPTH; i++) begin
			if (i_rst) begin
				stage_ff[i] <= '0;
			end else begin
				stage_ff[i] <= nxt_stage[i];
			end
		end
	end
endmodule
`default_nettype wire

/* File: verilog/sdc_core.sv */
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Column access: ras_n high, cas_n low; we_n picks read or write, address gives column.
// - cs_n, cas_n low with ras_n, we_n high starts a burst read.
// - Burst ordering and length come from the loaded mode register.
// - cs_n, cas_n, we_n low with ras_n high starts a burst write.
// - First write beat on command clock, then one per clock; extra data ignored.
// - Read interrupting read restarts full burst; old data runs until new latency.
// - Write interrupting write restarts full burst at the new column.
// - Read ends a write burst on its own clock; remaining write beats dropped.
// - Burst stop ends burst, keeps bank open; read output stops after latency.
// - Sequential order increments and wraps inside the burst-length low bits.
// - Interleaved order inverts low start-column bits by beat index.
// - Auto-precharge flag on access; read precharge starts latency clocks before end.
// - Write auto-precharge closes bank two clocks after the last write beat.
// - Precharge decode: cs_n, ras_n, we_n low, cas_n high; picks banks.
// - In self-refresh all inputs ignored but clock enable; high exits.
// - byte_mask hides read output two clocks later; blocks write beat at once.
// - Precharge samples auto_precharge_flag_bit for all banks or one bank.
module sdc_core import sdc_pkg::*; #(
	parameter int ROW_W = 2,
	parameter int MAX_LAT = 3
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// register bus
	input wire logic [AVS_AW-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// memory pins
	input wire sdc_pin_s i_pin,
	input wire logic [DQ_W-1:0] i_dq,
	output logic [DQ_W-1:0] o_dq,
	output logic o_dq_oe
);
	localparam int MEM_AW = BANK_W + ROW_W + COL_W;

	logic [DQ_W-1:0] mem [2**MEM_AW];

	// register bus state
	logic ack_ff, nxt_ack;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [MODE_W-1:0] mode_ff, nxt_mode;

	// bank and burst state
	logic cke_q_ff, nxt_cke_q;
	logic sr_ff, nxt_sr;
	logic [NBANK-1:0] open_ff, nxt_open;
	logic [ROW_W-1:0] row_ff [NBANK];
	logic [ROW_W-1:0] nxt_row [NBANK];
	logic rd_ff, nxt_rd;
	logic wr_ff, nxt_wr;
	logic ap_ff, nxt_ap;
	logic [BANK_W-1:0] bank_ff, nxt_bank;
	logic [COL_W-1:0] start_ff, nxt_start;
	logic [COL_W-1:0] beat_ff, nxt_beat;
	logic [1:0] wrec_ff, nxt_wrec;
	logic [BANK_W-1:0] wrec_bank_ff, nxt_wrec_bank;
	logic [1:0] dqm_d1_ff, dqm_d2_ff;
	sdc_beat_s memq_ff, nxt_memq;

	// decode and datapath
	sdc_cmd_e cmd;
	logic live;
	logic [2:0] len_code;
	logic ilv;
	logic [1:0] lat;
	logic [COL_W-1:0] col_cur, mask, cmd_col, rem;
	logic full;
	logic last;
	logic wr_en;
	logic [MEM_AW-1:0] wr_addr;
	logic [MEM_AW-1:0] rd_addr;
	sdc_beat_s pipe_out;

	assign len_code = mode_ff[MODE_LEN_LSB +: 3];
	assign ilv = mode_ff[MODE_ILV_BIT];
	assign lat = (mode_ff[MODE_LAT_LSB +: 2] < LAT_MIN) ? LAT_MIN : mode_ff[MODE_LAT_LSB +: 2];
	assign cmd_col = i_pin.addr[COL_W-1:0];

	sdc_col_gen u_col (
		.i_start(start_ff),
		.i_beat(beat_ff),
		.i_len(len_code),
		.i_ilv(ilv),
		.o_col(col_cur),
		.o_mask(mask),
		.o_full(full)
	);

	// command decode
	always_comb begin
		live = cke_q_ff && !sr_ff && !i_pin.cs_n;
		cmd = CMD_NOP;
		if (live) begin
			case ({i_pin.ras_n, i_pin.cas_n, i_pin.we_n})
				3'b011: cmd = CMD_ACT;
				3'b101: cmd = CMD_RD;
				3'b100: cmd = CMD_WR;
				3'b010: cmd = CMD_PRE;
				3'b110: cmd = CMD_BST;
				3'b001: cmd = i_pin.cke ? CMD_NOP : CMD_SREF;
				default: cmd = CMD_NOP;
			endcase
		end
	end

	// bank and burst next state
	always_comb begin
		nxt_cke_q = i_pin.cke;
		nxt_sr = sr_ff;
		nxt_open = open_ff;
		nxt_row = row_ff;
		nxt_rd = rd_ff;
		nxt_wr = wr_ff;
		nxt_ap = ap_ff;
		nxt_bank = bank_ff;
		nxt_start = start_ff;
		nxt_beat = beat_ff;
		nxt_wrec = wrec_ff;
		nxt_wrec_bank = wrec_bank_ff;
		wr_en = 1'b0;
		wr_addr = {bank_ff, row_ff[bank_ff], col_cur};
		rd_addr = {bank_ff, row_ff[bank_ff], col_cur};
		rem = mask - (beat_ff & mask);
		last = !full && ((beat_ff & mask) == mask);
		nxt_memq.valid = rd_ff;
		nxt_memq.data = mem[rd_addr];
		// write recovery before auto-precharge
		if (wrec_ff != 2'h0) begin
			nxt_wrec = wrec_ff - 2'h1;
			if (wrec_ff == 2'h1) begin
				nxt_open[wrec_bank_ff] = 1'b0;
			end
		end
		// running read burst
		if (rd_ff) begin
			if (ap_ff && int'(rem) < int'(lat)) begin
				nxt_open[bank_ff] = 1'b0;
			end
			if (last) begin
				nxt_rd = 1'b0;
			end
			nxt_beat = beat_ff + 9'h001;
		end
		// running write burst
		if (wr_ff) begin
			wr_en = 1'b1;
			if (last) begin
				nxt_wr = 1'b0;
				if (ap_ff) begin
					nxt_wrec = WR_RECOVERY_CYC;
					nxt_wrec_bank = bank_ff;
				end
			end
			nxt_beat = beat_ff + 9'h001;
		end
		// new command
		case (cmd)
			CMD_ACT: begin
				nxt_open[i_pin.bank] = 1'b1;
				nxt_row[i_pin.bank] = i_pin.addr[ROW_W-1:0];
			end
			CMD_RD: begin
				wr_en = 1'b0;
				nxt_wr = 1'b0;
				nxt_rd = 1'b1;
				nxt_bank = i_pin.bank;
				nxt_start = cmd_col;
				nxt_beat = 9'h000;
				nxt_ap = i_pin.addr[AP_BIT];
			end
			CMD_WR: begin
				wr_en = 1'b1;
				wr_addr = {i_pin.bank, row_ff[i_pin.bank], cmd_col};
				nxt_rd = 1'b0;
				nxt_wr = (mask != 9'h000);
				nxt_bank = i_pin.bank;
				nxt_start = cmd_col;
				nxt_beat = 9'h001;
				nxt_ap = i_pin.addr[AP_BIT];
				if (mask == 9'h000 && i_pin.addr[AP_BIT]) begin
					nxt_wrec = WR_RECOVERY_CYC;
					nxt_wrec_bank = i_pin.bank;
				end
			end
			CMD_PRE: begin
				if (i_pin.addr[AP_BIT]) begin
					nxt_open = '0;
				end else begin
					nxt_open[i_pin.bank] = 1'b0;
				end
			end
			CMD_BST: begin
				nxt_rd = 1'b0;
				nxt_wr = 1'b0;
				wr_en = 1'b0;
			end
			CMD_SREF: begin
				nxt_sr = 1'b1;
				nxt_rd = 1'b0;
				nxt_wr = 1'b0;
				wr_en = 1'b0;
			end
			default: begin
			end
		endcase
		// leave self-refresh on clock enable high
		if (sr_ff) begin
			nxt_rd = 1'b0;
			nxt_wr = 1'b0;
			wr_en = 1'b0;
			if (i_pin.cke) begin
				nxt_sr = 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cke_q_ff <= 1'b0;
			sr_ff <= 1'b0;
			open_ff <= '0;
			rd_ff <= 1'b0;
			wr_ff <= 1'b0;
			ap_ff <= 1'b0;
			bank_ff <= '0;
			start_ff <= '0;
			beat_ff <= '0;
			wrec_ff <= '0;
			wrec_bank_ff <= '0;
			memq_ff <= '0;
			dqm_d1_ff <= '0;
			dqm_d2_ff <= '0;
			for (int i = 0; i < NBANK; i++) begin
				row_ff[i] <= '0;
			end
		end else begin
			cke_q_ff <= nxt_cke_q;
			sr_ff <= nxt_sr;
			open_ff <= nxt_open;
			rd_ff <= nxt_rd;
			wr_ff <= nxt_wr;
			ap_ff <= nxt_ap;
			bank_ff <= nxt_bank;
			start_ff <= nxt_start;
			beat_ff <= nxt_beat;
			wrec_ff <= nxt_wrec;
			wrec_bank_ff <= nxt_wrec_bank;
			memq_ff <= nxt_memq;
			dqm_d1_ff <= i_pin.dqm;
			dqm_d2_ff <= dqm_d1_ff;
			row_ff <= nxt_row;
		end
	end

	// array write, byte lanes masked with no latency
	always_ff @(posedge i_clk) begin
		if (wr_en && !i_rst) begin
			for (int b = 0; b < DQM_W; b++) begin
				if (!i_pin.dqm[b]) begin
					mem[wr_addr][8*b +: 8] <= i_dq[8*b +: 8];
				end
			end
		end
	end

	// read latency line
	sdc_rd_pipe #(
		.DEPTH(MAX_LAT - 2)
	) u_pipe (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_beat(memq_ff),
		.i_sel(lat - LAT_MIN),
		.o_beat(pipe_out)
	);

	always_comb begin
		o_dq = pipe_out.data;
		o_dq_oe = pipe_out.valid && (dqm_d2_ff != 2'h3);
		if (dqm_d2_ff[0]) begin
			o_dq[7:0] = 8'h00;
		end
		if (dqm_d2_ff[1]) begin
			o_dq[15:8] = 8'h00;
		end
	end

	// register bus, one wait state
	always_comb begin
		nxt_ack = (i_avs_read || i_avs_write) && !ack_ff;
		nxt_mode = mode_ff;
		nxt_rdata = rdata_ff;
		if (i_avs_write && ack_ff && i_avs_address == REG_MODE) begin
			nxt_mode = i_avs_writedata[MODE_W-1:0];
		end
		if (i_avs_read && !ack_ff) begin
			case (i_avs_address)
				REG_MODE: nxt_rdata = {26'h000_0000, mode_ff};
				REG_STAT: nxt_rdata = {24'h00_0000, (wrec_ff != 2'h0), ap_ff, sr_ff, wr_ff, rd_ff,
					open_ff[2:0] == 3'h0 && open_ff[3] == 1'b0, 2'h0} | {28'h000_0000, open_ff} << 8;
				default: nxt_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ack_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			mode_ff <= MODE_RST;
		end else begin
			ack_ff <= nxt_ack;
			rdata_ff <= nxt_rdata;
			mode_ff <= nxt_mode;
		end
	end

	assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_ff;
	assign o_avs_readdata = rdata_ff;
endmodule
`default_nettype wire

/* File: test/sdc_ctl_model.sv */
`timescale 1ns/1ns
`default_nettype none
module sdc_ctl_model import sdc_pkg::*; (
	// clock
	input wire logic i_clk,
	// pins toward the device
	output sdc_pin_s o_pin,
	output logic [DQ_W-1:0] o_dq
);
	// encode one command, cke given by caller
	function automatic sdc_pin_s enc(sdc_cmd_e c, logic [1:0] b, logic [12:0] a, logic k);
		sdc_pin_s p;
		p = '{k, 1'b0, 1'b1, 1'b1, 1'b1, 2'h0, b, a};
		case (c)
			CMD_ACT: {p.ras_n, p.cas_n, p.we_n} = 3'h3;
			CMD_RD: {p.ras_n, p.cas_n, p.we_n} = 3'h5;
			CMD_WR: {p.ras_n, p.cas_n, p.we_n} = 3'h4;
			CMD_PRE: {p.ras_n, p.cas_n, p.we_n} = 3'h2;
			CMD_BST: {p.ras_n, p.cas_n, p.we_n} = 3'h6;
			CMD_SREF: {p.ras_n, p.cas_n, p.we_n} = 3'h1;
			default: p.cs_n = 1'b0;
		endcase
		return p;
	endfunction
	initial begin
		o_pin = enc(CMD_NOP, 2'h0, 13'h0000, 1'b1);
		o_dq = 16'h0000;
	end
	// one clock of pins; a released bus shows the inverted last value
	task automatic step(sdc_pin_s p, logic [DQ_W-1:0] d, logic drv);
		@(posedge i_clk);
		o_pin <= p;
		o_dq <= drv ? d : ~o_dq;
	endtask
endmodule
`default_nettype wire

/* File: test/sdc_core_checker.sv */
`timescale 1ns/1ns
`default_nettype none
module sdc_core_checker import sdc_pkg::*; (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// register bus
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] o_avs_readdata,
	input wire logic o_avs_waitrequest,
	// memory pins
	input wire sdc_pin_s i_pin,
	input wire logic o_dq_oe
);
	wire logic [2:0] code = {i_pin.ras_n, i_pin.cas_n, i_pin.we_n};
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	sequence s_cmd(logic [2:0] c);
		$past(i_pin.cke) && i_pin.cke && !i_pin.cs_n && code == c;
	endsequence
	sequence s_rd;
		s_cmd(3'h5) ##0 i_pin.dqm == 2'h0;
	endsequence
	a_bus_wait: assert property ($rose(i_avs_read || i_avs_write) |->
		o_avs_waitrequest ##1 !o_avs_waitrequest) else $error("bus wait wrong");
	a_bus_idle: assert property (!(i_avs_read || i_avs_write) |-> !o_avs_waitrequest)
		else $error("wait without request");
	a_rdata_hold: assert property (!(i_avs_read && o_avs_waitrequest) |=>
		$stable(o_avs_readdata)) else $error("read data moved");
	a_reset_quiet: assert property ($fell(i_rst) |-> !o_dq_oe && o_avs_readdata == 32'h0000_0000)
		else $error("reset state wrong");
	a_read_latency: assert property (s_rd |-> ##2 o_dq_oe)
		else $error("read data late");
	a_mask_hides: assert property (i_pin.dqm == 2'h3 |-> ##2 !o_dq_oe)
		else $error("masked beat driven");
	a_stop_release: assert property (s_cmd(3'h6) |-> ##2 !o_dq_oe)
		else $error("drive after stop");
	a_wake_ignore: assert property (!$past(i_pin.cke) && i_pin.cke && code == 3'h5 |->
		##2 !o_dq_oe) else $error("read taken on wake");
endmodule
bind sdc_core sdc_core_checker u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_avs_read(i_avs_read),
	.i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
	.o_avs_waitrequest(o_avs_waitrequest), .i_pin(i_pin), .o_dq_oe(o_dq_oe));
`default_nettype wire

/* File: test/test_sdram_burst_access_core.sv */
`timescale 1ns/1ns
`default_nettype none
module test_sdram_burst_access_core import sdc_pkg::*;;
	logic i_clk, i_rst, rd, wr;
	logic [3:0] adr;
	logic [31:0] wd, q;
	wire logic [31:0] rdata;
	wire logic wreq, oe;
	wire logic [DQ_W-1:0] dqi, dqo;
	wire sdc_pin_s pin;
	int miscompares = 0;
	int n_compared = 0;
	int cyc = 0;
	sdc_core dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_avs_address(adr), .i_avs_read(rd),
		.i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdata),
		.o_avs_waitrequest(wreq), .i_pin(pin), .i_dq(dqi), .o_dq(dqo), .o_dq_oe(oe));
	sdc_ctl_model u_ctl (.i_clk(i_clk), .o_pin(pin), .o_dq(dqi));
	initial begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end
	task automatic final_report();
		$display("compared %0d wrong %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
		rd <= !w;
		wr <= w;
		adr <= a;
		wd <= d;
		@(posedge i_clk);
		while (wreq) @(posedge i_clk);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge i_clk);
	endtask
	task automatic st(sdc_cmd_e c, logic [1:0] b, logic [12:0] a, logic [15:0] d = 16'h0000,
		logic drv = 1'b0, logic [1:0] dm = 2'h0);
		sdc_pin_s p;
		p = u_ctl.enc(c, b, a, 1'b1);
		p.dqm = dm;
		u_ctl.step(p, d, drv);
	endtask
	task automatic nop(int n);
		repeat (n) st(CMD_NOP, 2'h0, 13'h0000);
	endtask
	task automatic cmd(sdc_cmd_e c, logic [1:0] b, logic [12:0] a);
		st(c, b, a);
		nop(1);
	endtask
	task automatic wbeats(logic [12:0] a, logic [15:0] d, int n);
		st(CMD_WR, 2'h0, a, d, 1'b1);
		for (int k = 1; k < n; k++) st(CMD_NOP, 2'h0, 13'h0000, d + 16'(k), 1'b1);
	endtask
	// expected beats, last beat first
	task automatic rchk(logic [12:0] a, logic [3:0][15:0] e);
		cmd(CMD_RD, 2'h0, a);
		nop(1);
		for (int k = 0; k < 4; k++) begin
			#1;
			chk("read data", {16'h0000, e[k]}, {16'h0000, dqo});
			nop(1);
		end
	endtask
	task automatic stat(logic [31:0] e, logic [31:0] m);
		bus(1'b0, REG_STAT, 32'h0000_0000);
		chk("status", e, q & m);
	endtask
	task automatic t_regs();
		bus(1'b0, REG_MODE, 32'h0000_0000);
		chk("mode reset", 32'h0000_0023, q);
		bus(1'b1, 4'h8, 32'hffff_ffff);
		bus(1'b0, 4'h8, 32'h0000_0000);
		chk("unmapped", 32'h0000_0000, q);
		bus(1'b0, REG_MODE, 32'h0000_0000);
		chk("mode kept", 32'h0000_0023, q);
		stat(32'h0000_0004, 32'h0000_0f04);
		bus(1'b1, REG_MODE, 32'h0000_0022);
		$display("registers done");
	endtask
	task automatic t_order();
		cmd(CMD_ACT, 2'h0, 13'h0000);
		nop(2);
		wbeats(13'h0002, 16'h1000, 4);
		st(CMD_NOP, 2'h0, 13'h0000, 16'hdead, 1'b1);
		rchk(13'h0000, {16'h1001, 16'h1000, 16'h1003, 16'h1002});
		bus(1'b1, REG_MODE, 32'h0000_002a);
		rchk(13'h0001, {16'h1000, 16'h1001, 16'h1002, 16'h1003});
		$display("ordering done");
	endtask
	task automatic t_intr();
		bus(1'b1, REG_MODE, 32'h0000_0022);
		wbeats(13'h0004, 16'h4000, 2);
		wbeats(13'h0006, 16'h5000, 4);
		wbeats(13'h0000, 16'h6000, 2);
		st(CMD_RD, 2'h0, 13'h0004, 16'h6002, 1'b1);
		rchk(13'h0000, {16'h1001, 16'h1000, 16'h6001, 16'h6000});
		rchk(13'h0004, {16'h5001, 16'h5000, 16'h5003, 16'h5002});
		$display("interrupts done");
	endtask
	task automatic t_stop();
		bus(1'b1, REG_MODE, 32'h0000_0027);
		cmd(CMD_RD, 2'h0, 13'h0000);
		cmd(CMD_BST, 2'h0, 13'h0000);
		#1;
		chk("beat before stop", 32'h0000_6001, {16'h0000, dqo});
		nop(1);
		#1;
		chk("stop drive", 32'h0000_0000, {31'h0000_0000, oe});
		nop(1);
		bus(1'b1, REG_MODE, 32'h0000_0022);
		st(CMD_RD, 2'h0, 13'h0000, 16'h0000, 1'b0, 2'h3);
		nop(2);
		#1;
		chk("masked drive", 32'h0000_0000, {31'h0000_0000, oe});
		nop(1);
		#1;
		chk("open beat", 32'h0000_6001, {16'h0000, dqo});
		nop(3);
		$display("stop and mask done");
	endtask
	task automatic t_bank();
		cmd(CMD_ACT, 2'h1, 13'h0000);
		nop(2);
		cmd(CMD_PRE, 2'h1, 13'h0000);
		stat(32'h0000_0100, 32'h0000_0f04);
		cmd(CMD_PRE, 2'h0, 13'h0400);
		stat(32'h0000_0004, 32'h0000_0f04);
		nop(3);
		cmd(CMD_ACT, 2'h0, 13'h0000);
		nop(2);
		wbeats(13'h0400, 16'h7000, 4);
		nop(2);
		stat(32'h0000_0100, 32'h0000_0f04);
		stat(32'h0000_0004, 32'h0000_0f04);
		cmd(CMD_ACT, 2'h0, 13'h0000);
		nop(2);
		rchk(13'h0400, {16'h7003, 16'h7002, 16'h7001, 16'h7000});
		stat(32'h0000_0004, 32'h0000_0f04);
		$display("banks done");
	endtask
	task automatic t_sref();
		u_ctl.step(u_ctl.enc(CMD_SREF, 2'h0, 13'h0000, 1'b0), 16'h0000, 1'b0);
		@(posedge i_clk);
		stat(32'h0000_0020, 32'h0000_0020);
		u_ctl.step(u_ctl.enc(CMD_RD, 2'h0, 13'h0000, 1'b1), 16'h0000, 1'b0);
		nop(2);
		#1;
		chk("wake drive", 32'h0000_0000, {31'h0000_0000, oe});
		nop(1);
		stat(32'h0000_0000, 32'h0000_0020);
		$display("self refresh done");
	endtask
	initial begin
		i_rst = 1'b1;
		rd = 1'b0;
		wr = 1'b0;
		adr = 4'h0;
		wd = 32'h0000_0000;
		repeat (2) @(posedge i_clk);
		i_rst <= 1'b0;
		nop(2);
		t_regs();
		t_order();
		t_intr();
		t_stop();
		t_bank();
		t_sref();
		final_report();
	end
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			miscompares++;
			final_report();
		end
	end
endmodule
`default_nettype wire
